// ==== tb/hrcd_home_seq_tb_top.sv ====
// Self-checking bench for the home return sequencer
`timescale 1ns/10ps
module hrcd_home_seq_tb_top
  import hrcd_pkg::*;
;
  localparam logic [31:0] V_HSPD = 32'h0000_0123;
  localparam logic [31:0] V_CSPD = 32'h0000_0045;
  localparam logic [31:0] V_JSPD = 32'h0000_0077;
  localparam int TRAVEL = 5;
  localparam int SHIFT = 3;

  logic clk_sys_i = 1'b0;
  logic srst_i = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  // Mode selects: {source, point 5..1, auto/manual}
  logic [6:0] sel = 7'h01;
  logic dog = 1'b0;
  logic start = 1'b0;
  logic jog_f = 1'b0;
  logic jog_r = 1'b0;
  logic stop_c = 1'b0;
  logic [31:0] rdata, position, exp_pos;
  logic stp, zero, move_en, dir_neg, done, err;
  logic [15:0] speed, acc, dec;
  int err_count = 0;
  int n_checks = 0;

  hrcd_home_seq dut_u (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .auto_manual_select_in_i(sel[0]),
    .point_sel_bit1_in_i(sel[1]), .point_sel_bit2_in_i(sel[2]), .point_sel_bit3_in_i(sel[3]),
    .point_sel_bit4_in_i(sel[4]), .point_sel_bit5_in_i(sel[5]), .pos_speed_source_select_in_i(sel[6]),
    .proximity_dog_in_i(dog), .home_start_i(start), .jog_fwd_i(jog_f), .jog_rev_i(jog_r),
    .feedback_step_i(stp), .zero_pulse_i(zero), .stopper_contact_i(stop_c), .move_en_o(move_en),
    .dir_neg_o(dir_neg), .speed_cmd_o(speed), .acc_time_o(acc), .dec_time_o(dec),
    .position_o(position), .home_done_o(done), .home_err_o(err));

  hrcd_host_model host_u (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .move_en_i(move_en),
    .feedback_step_o(stp), .zero_pulse_o(zero));

  // 40 MHz clock
  initial
  begin
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Register port master: strobes one cycle, read data taken in the cycle after
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys_i);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys_i);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_sys_i);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // Start pulse long enough for the synchroniser, then wait bounded for an outcome or for motion
  task automatic kick_and_wait();
    int i;
    @(posedge clk_sys_i);
    start <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    start <= 1'b0;
    for (i = 0; i < 900; i++)
    begin
      @(posedge clk_sys_i);
      #1;
      if (done === 1'b1 || err === 1'b1 || move_en === 1'b1)
        return;
    end
    chk(32'h1, 32'h0, "timeout");
    tally_and_finish();
  endtask

  task automatic t_regs();
    logic [31:0] d;
    int a;
    for (a = 0; a <= 'h28; a += 4)
    begin
      rd_reg(8'(a), d);
      if (a != 'h24)
        chk(d, 32'h0, "reset value");
    end
    rd_reg(8'h40, d);
    chk(d, 32'h0, "unmapped read");
    wr_reg(HRCD_OFF_HOME_SPD, V_HSPD);
    wr_reg(HRCD_OFF_POSITION, 32'h0000_00FF);
    rd_reg(HRCD_OFF_HOME_SPD, d);
    chk(d, V_HSPD, "readback");
    @(posedge clk_sys_i);
    #1;
    chk(rdata, 32'h0, "read data after its cycle");
    rd_reg(HRCD_OFF_POSITION, d);
    chk(d, 32'h0, "read-only write ignored");
  endtask

  task automatic t_jog();
    @(posedge clk_sys_i);
    jog_f <= 1'b1;
    repeat (20) @(posedge clk_sys_i);
    #1;
    chk({29'h0, move_en, dir_neg, speed == V_JSPD[15:0]}, 32'h5, "jog forward");
    @(posedge clk_sys_i);
    jog_f <= 1'b0;
    jog_r <= 1'b1;
    repeat (20) @(posedge clk_sys_i);
    #1;
    chk({29'h0, move_en, dir_neg, speed == V_JSPD[15:0]}, 32'h7, "jog reverse");
    @(posedge clk_sys_i);
    jog_r <= 1'b0;
    repeat (20) @(posedge clk_sys_i);
  endtask

  // Present position, wherever jog left it, becomes home
  task automatic t_data(input logic [31:0] pos);
    logic [31:0] d;
    wr_reg(HRCD_OFF_HOME_POS, pos);
    wr_reg(HRCD_OFF_CFG, 32'h0000_0002);
    kick_and_wait();
    chk({30'h0, done, err}, 32'h2, "data set outcome");
    chk(position, pos, "data set position");
    // Mode good, dog seen with input low, idle, done only
    rd_reg(HRCD_OFF_STATUS, d);
    chk(d, 32'h0000_00C1, "status after data set");
    exp_pos = pos;
  endtask

  task automatic t_count(input logic dir, input logic pol, input logic [31:0] pos);
    int i;
    int n;
    logic prv;
    wr_reg(HRCD_OFF_HOME_POS, pos);
    wr_reg(HRCD_OFF_CFG, {23'h0, pol, 3'h0, dir, 4'h1});
    dog <= ~pol;
    kick_and_wait();
    chk({30'h0, done, err}, 32'h0, "count running");
    chk({30'h0, move_en, dir_neg}, {30'h0, 1'b1, dir}, "start direction");
    chk({16'h0, speed}, V_HSPD, "home speed");
    chk({acc, dec}, 32'h0A0B_0C0D, "accel decel from table entry one");
    repeat (24) @(posedge clk_sys_i);
    #1;
    chk({16'h0, speed}, V_HSPD, "inactive dog level ignored");
    n = 0;
    prv = stp;
    @(posedge clk_sys_i);
    dog <= pol;
    for (i = 0; i < 900 && done !== 1'b1; i++)
    begin
      @(posedge clk_sys_i);
      #1;
      if (stp && !prv)
        n++;
      prv = stp;
      if (i == 6)
        chk({16'h0, speed}, V_CSPD, "creep speed");
    end
    chk({31'h0, n >= TRAVEL + SHIFT && n <= TRAVEL + SHIFT + 6}, 32'h1, "steps dog to home");
    chk({30'h0, done, move_en}, 32'h2, "count done");
    chk(position, pos, "count position");
    @(posedge clk_sys_i);
    dog <= ~pol;
    exp_pos = pos;
  endtask

  task automatic t_stop();
    wr_reg(HRCD_OFF_HOME_POS, 32'h0000_0777);
    wr_reg(HRCD_OFF_CFG, 32'h0000_0013);
    kick_and_wait();
    chk({29'h0, move_en, dir_neg, done}, 32'h6, "pressing toward stopper");
    @(posedge clk_sys_i);
    stop_c <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
    #1;
    chk({30'h0, done, move_en}, 32'h2, "stopper done");
    chk(position, 32'h0000_0777, "stopper position");
    @(posedge clk_sys_i);
    stop_c <= 1'b0;
    exp_pos = 32'h0000_0777;
  endtask

  // Each mode select wrong in turn, then an unknown method digit
  task automatic t_mode();
    int i;
    wr_reg(HRCD_OFF_HOME_POS, 32'h0000_5A5A);
    wr_reg(HRCD_OFF_CFG, 32'h0000_0002);
    for (i = 0; i < 7; i++)
    begin
      @(posedge clk_sys_i);
      sel <= 7'h01 ^ (7'h01 << i);
      repeat (4) @(posedge clk_sys_i);
      kick_and_wait();
      chk({30'h0, done, err}, 32'h1, "wrong mode refused");
      chk(position, exp_pos, "position kept");
      @(posedge clk_sys_i);
      sel <= 7'h01;
    end
    wr_reg(HRCD_OFF_CFG, 32'h0000_0004);
    kick_and_wait();
    chk({30'h0, done, err}, 32'h1, "unknown method");
  endtask

  // Main sequence
  initial
  begin
    exp_pos = 32'h0;
    repeat (8) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    t_regs();
    wr_reg(HRCD_OFF_CREEP_SPD, V_CSPD);
    wr_reg(HRCD_OFF_JOG_SPD, V_JSPD);
    wr_reg(HRCD_OFF_TRAVEL, TRAVEL);
    wr_reg(HRCD_OFF_SHIFT, SHIFT);
    wr_reg(HRCD_OFF_ACC, 32'h0000_0A0B);
    wr_reg(HRCD_OFF_DEC, 32'h0000_0C0D);
    t_jog();
    t_data(32'h0000_1234);
    t_count(1'b1, 1'b1, 32'h0000_0321);
    t_count(1'b0, 1'b0, 32'h0000_0456);
    t_stop();
    t_mode();
    tally_and_finish();
  end
endmodule

// ==== tb/hrcd_host_model.sv ====
// Machine side model: encoder step and zero pulse that start only while motion is commanded, then finish the step under way
`timescale 1ns/10ps
module hrcd_host_model (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // Motion request from the block
  input wire logic move_en_i,
  // Encoder lines
  output logic feedback_step_o,
  output logic zero_pulse_o
);
  logic [2:0] ph_q;
  logic [1:0] rev_q;

  // One step every 8 cycles; a started step always completes, so no runt edges
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      ph_q <= 3'h0;
      rev_q <= 2'h0;
    end
    else if (move_en_i || ph_q != 3'h0)
    begin
      ph_q <= ph_q + 3'h1;
      if (ph_q == 3'h7)
        rev_q <= rev_q + 2'h1;
    end
  end

  // Zero pulse on every fourth step, four cycles wide to survive the synchroniser
  assign feedback_step_o = ph_q[2];
  assign zero_pulse_o = ph_q[2] & (rev_q == 2'h3);
endmodule

// ==== verilog/hrcd_home_seq.sv ====
// Home return sequencer: count, data setting and stopper homing with register port
`timescale 1ns/10ps
// Operation
// R01: Host selects manual home mode: auto/manual on, all point selects off.
// R02: Host keeps position/speed source select off during home return.
// R03: Method digit 1 selects count type homing.
// R04: Count homing runs at home return speed until the dog is seen.
// R05: After dog detection speed drops to creep speed.
// R06: After dog front end, travel the set distance before looking for zero pulse.
// R07: Home is shifted by shift distance from first zero pulse after travel.
// R08: Count homing uses acceleration/deceleration constants of point table entry one.
// R09: On any completed homing, home position data becomes current position.
// R10: Method digit 2 selects data setting homing: present position becomes home.
// R11: Data setting homing needs no dog or zero pulse; any position allowed.
// R12: Jog may move the axis before data setting homing.
// R13: Stopper homing: home is where the part presses against the stopper.
// R14: Direction digit 0 moves to increasing addresses, 1 to decreasing.
// R15: Polarity digit 0 detects dog when input off, 1 when on.
// R16: Host keeps the dog input asserted at least 10 ms.
// R17: Wrong mode selects at start: homing fails, position unchanged.
module hrcd_home_seq
  import hrcd_pkg::*;
#(
  parameter int POS_W = 32,
  parameter int SPD_W = 16
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // Remote inputs from the host controller
  input wire logic auto_manual_select_in_i,
  input wire logic point_sel_bit1_in_i,
  input wire logic point_sel_bit2_in_i,
  input wire logic point_sel_bit3_in_i,
  input wire logic point_sel_bit4_in_i,
  input wire logic point_sel_bit5_in_i,
  input wire logic pos_speed_source_select_in_i,
  input wire logic proximity_dog_in_i,
  input wire logic home_start_i,
  input wire logic jog_fwd_i,
  input wire logic jog_rev_i,
  // Machine side inputs
  input wire logic feedback_step_i,
  input wire logic zero_pulse_i,
  input wire logic stopper_contact_i,
  // Motion command
  output logic move_en_o,
  output logic dir_neg_o,
  output logic [SPD_W-1:0] speed_cmd_o,
  output logic [15:0] acc_time_o,
  output logic [15:0] dec_time_o,
  // Homing result
  output logic [POS_W-1:0] position_o,
  output logic home_done_o,
  output logic home_err_o
);

  localparam int NSYNC = 14;

  // Register address match, used by write and read decode
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
    reg_hit = (addr == off);
  endfunction

  // Synchronised pins
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] pin_s;
  logic [4:0] point_sel_s;
  logic auto_s;
  logic src_sel_s;
  logic dog_s;
  logic start_s;
  logic jog_fwd_s;
  logic jog_rev_s;
  logic step_s;
  logic zero_s;
  logic stopper_s;

  assign pin_raw = {stopper_contact_i, zero_pulse_i, feedback_step_i, jog_rev_i, jog_fwd_i, home_start_i,
                    proximity_dog_in_i, pos_speed_source_select_in_i, auto_manual_select_in_i,
                    point_sel_bit5_in_i, point_sel_bit4_in_i, point_sel_bit3_in_i, point_sel_bit2_in_i,
                    point_sel_bit1_in_i};

  // Every pin is asynchronous to the sequencer clock
  hrcd_sync #(
    .WIDTH(NSYNC)
  ) u_sync (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .d_i(pin_raw),
    .q_o(pin_s)
  );

  assign point_sel_s = pin_s[4:0];
  assign auto_s = pin_s[5];
  assign src_sel_s = pin_s[6];
  assign dog_s = pin_s[7];
  assign start_s = pin_s[8];
  assign jog_fwd_s = pin_s[9];
  assign jog_rev_s = pin_s[10];
  assign step_s = pin_s[11];
  assign zero_s = pin_s[12];
  assign stopper_s = pin_s[13];

  // Edge detection on synchronised pulses
  logic [2:0] edge_q;
  logic [2:0] edge_d;
  logic start_rise;
  logic step_rise;
  logic zero_rise;

  always_comb
  begin
    edge_d = {zero_s, step_s, start_s};
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      edge_q <= 3'h0;
    else
      edge_q <= edge_d;
  end

  assign start_rise = start_s & ~edge_q[0];
  assign step_rise = step_s & ~edge_q[1];
  assign zero_rise = zero_s & ~edge_q[2];

  // Register file
  logic [HRCD_CFG_W-1:0] cfg_q, cfg_d;
  logic [15:0] home_spd_q, home_spd_d;
  logic [15:0] creep_spd_q, creep_spd_d;
  logic [15:0] jog_spd_q, jog_spd_d;
  logic [15:0] acc_q, acc_d;
  logic [15:0] dec_q, dec_d;
  logic [31:0] shift_q, shift_d;
  logic [31:0] hpos_q, hpos_d;
  logic [31:0] travel_q, travel_d;
  logic [31:0] rdata_q, rdata_d;

  // Sequencer state
  hrcd_state_t state_q, state_d;
  logic [31:0] cnt_q, cnt_d;
  logic [POS_W-1:0] pos_q, pos_d;
  logic done_q, done_d;
  logic err_q, err_d;
  logic dir_neg_q, dir_neg_d;
  logic move_q, move_d;
  logic [SPD_W-1:0] spd_q, spd_d;

  logic [3:0] method;
  logic cfg_dir_neg;
  logic dog_det;
  logic mode_ok;
  logic jog_req;

  assign method = cfg_q[HRCD_CFG_METHOD_LSB +: 4];
  assign cfg_dir_neg = cfg_q[HRCD_CFG_DIR_LSB]; // R14
  // Polarity bit 0 means the dog reads active while its input is off
  assign dog_det = cfg_q[HRCD_CFG_POL_LSB] ? dog_s : ~dog_s; // R15
  // Manual home return mode with position/speed taken from parameters
  assign mode_ok = auto_s & ~(|point_sel_s) & ~src_sel_s; // R01 R02
  assign jog_req = jog_fwd_s ^ jog_rev_s; // R12

  // Register writes and read data
  always_comb
  begin
    cfg_d = cfg_q;
    home_spd_d = home_spd_q;
    creep_spd_d = creep_spd_q;
    jog_spd_d = jog_spd_q;
    acc_d = acc_q;
    dec_d = dec_q;
    shift_d = shift_q;
    hpos_d = hpos_q;
    travel_d = travel_q;
    rdata_d = 32'h0000_0000;
    if (reg_wr_i)
    begin
      if (reg_hit(reg_addr_i, HRCD_OFF_CFG)) cfg_d = reg_wdata_i[HRCD_CFG_W-1:0];
      if (reg_hit(reg_addr_i, HRCD_OFF_HOME_SPD)) home_spd_d = reg_wdata_i[15:0];
      if (reg_hit(reg_addr_i, HRCD_OFF_CREEP_SPD)) creep_spd_d = reg_wdata_i[15:0];
      if (reg_hit(reg_addr_i, HRCD_OFF_JOG_SPD)) jog_spd_d = reg_wdata_i[15:0];
      if (reg_hit(reg_addr_i, HRCD_OFF_ACC)) acc_d = reg_wdata_i[15:0];
      if (reg_hit(reg_addr_i, HRCD_OFF_DEC)) dec_d = reg_wdata_i[15:0];
      if (reg_hit(reg_addr_i, HRCD_OFF_SHIFT)) shift_d = reg_wdata_i;
      if (reg_hit(reg_addr_i, HRCD_OFF_HOME_POS)) hpos_d = reg_wdata_i;
      if (reg_hit(reg_addr_i, HRCD_OFF_TRAVEL)) travel_d = reg_wdata_i;
    end
    // Unmapped addresses read as zero
    if (reg_rd_i)
    begin
      if (reg_hit(reg_addr_i, HRCD_OFF_CFG)) rdata_d = {20'h00000, cfg_q};
      if (reg_hit(reg_addr_i, HRCD_OFF_HOME_SPD)) rdata_d = {16'h0000, home_spd_q};
      if (reg_hit(reg_addr_i, HRCD_OFF_CREEP_SPD)) rdata_d = {16'h0000, creep_spd_q};
      if (reg_hit(reg_addr_i, HRCD_OFF_JOG_SPD)) rdata_d = {16'h0000, jog_spd_q};
      if (reg_hit(reg_addr_i, HRCD_OFF_ACC)) rdata_d = {16'h0000, acc_q};
      if (reg_hit(reg_addr_i, HRCD_OFF_DEC)) rdata_d = {16'h0000, dec_q};
      if (reg_hit(reg_addr_i, HRCD_OFF_SHIFT)) rdata_d = shift_q;
      if (reg_hit(reg_addr_i, HRCD_OFF_HOME_POS)) rdata_d = hpos_q;
      if (reg_hit(reg_addr_i, HRCD_OFF_TRAVEL)) rdata_d = travel_q;
      if (reg_hit(reg_addr_i, HRCD_OFF_STATUS))
        rdata_d = {24'h000000, mode_ok, dog_det, state_q, move_q, err_q, done_q};
      if (reg_hit(reg_addr_i, HRCD_OFF_POSITION)) rdata_d = pos_q;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      cfg_q <= HRCD_CFG_RST;
      home_spd_q <= HRCD_SPD_RST;
      creep_spd_q <= HRCD_SPD_RST;
      jog_spd_q <= HRCD_SPD_RST;
      acc_q <= HRCD_SPD_RST;
      dec_q <= HRCD_SPD_RST;
      shift_q <= HRCD_DIST_RST;
      hpos_q <= HRCD_DIST_RST;
      travel_q <= HRCD_DIST_RST;
      rdata_q <= HRCD_DIST_RST;
    end
    else
    begin
      cfg_q <= cfg_d;
      home_spd_q <= home_spd_d;
      creep_spd_q <= creep_spd_d;
      jog_spd_q <= jog_spd_d;
      acc_q <= acc_d;
      dec_q <= dec_d;
      shift_q <= shift_d;
      hpos_q <= hpos_d;
      travel_q <= travel_d;
      rdata_q <= rdata_d;
    end
  end

  // Sequencer next state; a mode change mid-run aborts rather than finishing on stale selects
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    pos_d = pos_q;
    done_d = done_q;
    err_d = err_q;
    dir_neg_d = dir_neg_q;
    if (step_rise && move_q)
      pos_d = dir_neg_q ? pos_q - POS_W'(1) : pos_q + POS_W'(1);
    if (state_q != HRCD_S_IDLE && !mode_ok)
    begin
      state_d = HRCD_S_IDLE;
      err_d = 1'b1; // R17
    end
    else
    begin
      case (state_q)
        HRCD_S_IDLE:
        begin
          if (jog_req)
            dir_neg_d = jog_rev_s; // R12
          if (start_rise)
          begin
            done_d = 1'b0;
            err_d = 1'b0;
            if (!mode_ok)
              err_d = 1'b1; // R17
            else if (method == HRCD_METHOD_COUNT)
            begin
              state_d = HRCD_S_FAST; // R03
              dir_neg_d = cfg_dir_neg; // R14
            end
            else if (method == HRCD_METHOD_DATA_SET)
            begin
              pos_d = hpos_q[POS_W-1:0]; // R10 R11 R09
              done_d = 1'b1;
            end
            else if (method == HRCD_METHOD_STOPPER)
            begin
              state_d = HRCD_S_STOPPER; // R13
              dir_neg_d = cfg_dir_neg; // R14
            end
            else
              err_d = 1'b1;
          end
        end
        HRCD_S_FAST:
        begin
          // Dog held 10 ms by the host, so no debounce is needed here
          if (dog_det)
          begin
            state_d = HRCD_S_TRAVEL; // R05 R16
            cnt_d = travel_q; // R06
          end
        end
        HRCD_S_TRAVEL:
        begin
          if (cnt_q == 32'h0000_0000)
            state_d = HRCD_S_SEEK_Z; // R06
          else if (step_rise)
            cnt_d = cnt_q - 32'h0000_0001;
        end
        HRCD_S_SEEK_Z:
        begin
          if (zero_rise)
          begin
            state_d = HRCD_S_SHIFT; // R07
            cnt_d = shift_q;
          end
        end
        HRCD_S_SHIFT:
        begin
          if (cnt_q == 32'h0000_0000)
          begin
            state_d = HRCD_S_IDLE;
            pos_d = hpos_q[POS_W-1:0]; // R09
            done_d = 1'b1;
          end
          else if (step_rise)
            cnt_d = cnt_q - 32'h0000_0001; // R07
        end
        HRCD_S_STOPPER:
        begin
          if (stopper_s)
          begin
            state_d = HRCD_S_IDLE; // R13
            pos_d = hpos_q[POS_W-1:0]; // R09
            done_d = 1'b1;
          end
        end
        default:
          state_d = HRCD_S_IDLE;
      endcase
    end
  end

  // Motion command follows the next state so it lines up with the state register
  always_comb
  begin
    move_d = 1'b1;
    case (state_d)
      HRCD_S_FAST: spd_d = home_spd_q[SPD_W-1:0]; // R04
      HRCD_S_STOPPER: spd_d = home_spd_q[SPD_W-1:0];
      HRCD_S_TRAVEL, HRCD_S_SEEK_Z, HRCD_S_SHIFT: spd_d = creep_spd_q[SPD_W-1:0]; // R05
      default:
      begin
        move_d = jog_req;
        spd_d = jog_req ? jog_spd_q[SPD_W-1:0] : '0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      state_q <= HRCD_S_IDLE;
      cnt_q <= HRCD_DIST_RST;
      pos_q <= '0;
      done_q <= 1'b0;
      err_q <= 1'b0;
      dir_neg_q <= 1'b0;
      move_q <= 1'b0;
      spd_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      pos_q <= pos_d;
      done_q <= done_d;
      err_q <= err_d;
      dir_neg_q <= dir_neg_d;
      move_q <= move_d;
      spd_q <= spd_d;
    end
  end

  // Outputs
  assign reg_rdata_o = rdata_q;
  assign move_en_o = move_q;
  assign dir_neg_o = dir_neg_q;
  assign speed_cmd_o = spd_q;
  assign acc_time_o = acc_q; // R08
  assign dec_time_o = dec_q; // R08
  assign position_o = pos_q;
  assign home_done_o = done_q;
  assign home_err_o = err_q;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);

  a_count_select: assert property (state_q == HRCD_S_IDLE && start_rise && mode_ok && method == HRCD_METHOD_COUNT
    |=> state_q == HRCD_S_FAST && dir_neg_q == $past(cfg_dir_neg)) else $error("count homing not started"); // R03
  a_fast_speed: assert property (state_q == HRCD_S_FAST && $past(state_q) == HRCD_S_FAST
    |-> speed_cmd_o == $past(home_spd_q[SPD_W-1:0]) && move_en_o) else $error("wrong home speed"); // R04
  a_creep_speed: assert property (state_q == HRCD_S_SEEK_Z && $past(state_q) == HRCD_S_SEEK_Z
    |-> speed_cmd_o == $past(creep_spd_q[SPD_W-1:0])) else $error("wrong creep speed"); // R05
  a_dog_travel: assert property (state_q == HRCD_S_FAST && dog_det && mode_ok
    |=> state_q == HRCD_S_TRAVEL && cnt_q == $past(travel_q)) else $error("dog travel not loaded"); // R06
  a_travel_done: assert property (state_q == HRCD_S_SEEK_Z && $past(state_q) == HRCD_S_TRAVEL
    |-> $past(cnt_q) == 32'h0000_0000) else $error("zero search before travel end"); // R06
  a_shift_load: assert property (state_q == HRCD_S_SEEK_Z && zero_rise && mode_ok
    |=> state_q == HRCD_S_SHIFT && cnt_q == $past(shift_q)) else $error("shift not loaded"); // R07
  a_home_load: assert property (state_q == HRCD_S_SHIFT && cnt_q == 32'h0000_0000 && mode_ok
    |=> done_q && state_q == HRCD_S_IDLE && pos_q == $past(hpos_q[POS_W-1:0])) else $error("home not set"); // R09
  a_data_set: assert property (state_q == HRCD_S_IDLE && start_rise && mode_ok && method == HRCD_METHOD_DATA_SET
    |=> done_q && pos_q == $past(hpos_q[POS_W-1:0]) && state_q == HRCD_S_IDLE) else $error("data set failed"); // R10
  a_stopper_home: assert property (state_q == HRCD_S_STOPPER && stopper_s && mode_ok
    |=> done_q && pos_q == $past(hpos_q[POS_W-1:0])) else $error("stopper home not set"); // R13
  a_mode_reject: assert property (state_q == HRCD_S_IDLE && start_rise && !mode_ok
    |=> err_q && !done_q && state_q == HRCD_S_IDLE) else $error("bad mode accepted"); // R17

  c_count_done: cover property (state_q == HRCD_S_SHIFT ##1 state_q == HRCD_S_IDLE && done_q);
  c_data_set: cover property (start_rise && method == HRCD_METHOD_DATA_SET ##1 done_q);
  c_stopper_done: cover property (state_q == HRCD_S_STOPPER ##1 state_q == HRCD_S_IDLE && done_q);
  c_mode_reject: cover property (start_rise && !mode_ok ##1 err_q);

endmodule

// ==== verilog/hrcd_pkg.sv ====
// Package with register map, field layout and reset values of the homing sequencer
package hrcd_pkg;

  // Register byte offsets
  localparam logic [7:0] HRCD_OFF_CFG = 8'h00;
  localparam logic [7:0] HRCD_OFF_HOME_SPD = 8'h04;
  localparam logic [7:0] HRCD_OFF_CREEP_SPD = 8'h08;
  localparam logic [7:0] HRCD_OFF_SHIFT = 8'h0C;
  localparam logic [7:0] HRCD_OFF_HOME_POS = 8'h10;
  localparam logic [7:0] HRCD_OFF_TRAVEL = 8'h14;
  localparam logic [7:0] HRCD_OFF_ACC = 8'h18;
  localparam logic [7:0] HRCD_OFF_DEC = 8'h1C;
  localparam logic [7:0] HRCD_OFF_JOG_SPD = 8'h20;
  localparam logic [7:0] HRCD_OFF_STATUS = 8'h24;
  localparam logic [7:0] HRCD_OFF_POSITION = 8'h28;

  // Homing configuration fields (one digit per nibble)
  localparam int HRCD_CFG_W = 12;
  localparam int HRCD_CFG_METHOD_LSB = 0;
  localparam int HRCD_CFG_DIR_LSB = 4;
  localparam int HRCD_CFG_POL_LSB = 8;

  // Method digit encodings
  localparam logic [3:0] HRCD_METHOD_COUNT = 4'h1;
  localparam logic [3:0] HRCD_METHOD_DATA_SET = 4'h2;
  localparam logic [3:0] HRCD_METHOD_STOPPER = 4'h3;

  // Values after reset
  localparam logic [11:0] HRCD_CFG_RST = 12'h000;
  localparam logic [15:0] HRCD_SPD_RST = 16'h0000;
  localparam logic [31:0] HRCD_DIST_RST = 32'h0000_0000;

  // Sequencer states
  typedef enum logic [2:0] {
    HRCD_S_IDLE,
    HRCD_S_FAST,
    HRCD_S_TRAVEL,
    HRCD_S_SEEK_Z,
    HRCD_S_SHIFT,
    HRCD_S_STOPPER
  } hrcd_state_t;

endpackage

// ==== verilog/hrcd_sync.sv ====
// Two flip-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/10ps
module hrcd_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // Data
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;

endmodule
